// ===== odsp_defines.svh
/*
 * Constants of the octal converter serial write port: register offsets,
 * field positions, reset values, command nibbles and edge counts.
 * Assumes inclusion by bare name from the main module only.
 */
// Function
// - A complete frame is sixteen falling edges
// - Shift data in on each falling edge
// - Sixteenth falling edge captures the last bit
// - Rising sync after complete frame executes command
// - Sync rising before edge fifteen aborts the write
// - Sync held past seventeen passes bits out
// - Chains shift multiples of sixteen, one execute
// - Codes are straight binary 0 to 4095
// - Channels A-D low reference, E-H high
// - Eight 12-bit registers, mode decides output update
// - Bit 15 clear: channel 14:12, code 11:0
// - Reset register-only; 1000 register-only, 1001 write-through
// - Output low 14 edges, high 15th, then data
// - 1010 updates all; 1011 writes A, updates all
`ifndef ODSP_DEFINES_SVH
`define ODSP_DEFINES_SVH

// Register byte offsets
`define ODSP_OFF_CONTROL   8'h00
`define ODSP_OFF_STATUS    8'h04
`define ODSP_OFF_HELD_BASE 8'h20
`define ODSP_OFF_OUT_BASE  8'h40

// Control and status fields
`define ODSP_CTRL_EN_BIT   0
`define ODSP_CTRL_EN_RST   1'b1
`define ODSP_MODE_RST      1'b0

// Command word fields and nibbles
`define ODSP_CMD_REG_ONLY  4'h8
`define ODSP_CMD_WR_THRU   4'h9
`define ODSP_CMD_UPD_ALL   4'ha
`define ODSP_CMD_CHAN_A    4'hb

// Falling edge counts within a frame
`define ODSP_EDGE_LOW_LAST 5'h0e
`define ODSP_EDGE_ABORT    5'h0f
`define ODSP_EDGE_FULL     5'h10

// AXI responses
`define ODSP_RESP_OKAY     2'h0
`define ODSP_RESP_SLVERR   2'h2
`define ODSP_RESP_DECERR   2'h3

`endif

// ===== odsp_pkg.sv
/*
 * Types of the octal converter serial write port.
 * Assumes odsp_defines.svh is reachable by bare name.
 */
package odsp_pkg;

	// Link sequencer states
	typedef enum logic [0:0] {
		LINK_IDLE,
		LINK_FRAME
	} odsp_link_t;

	// Whole state of the main module
	typedef struct packed {
		odsp_link_t        link;
		logic              sclk_q;
		logic [15:0]       shreg;
		logic [4:0]        edges;
		logic [3:0]        pos;
		logic              dout;
		logic              wt_mode;
		logic [7:0][11:0]  held;
		logic [7:0][11:0]  outc;
		logic [15:0]       last_cmd;
		logic [7:0]        aborts;
		logic              link_en;
		logic              aw_have;
		logic              w_have;
		logic [7:0]        awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} odsp_state_t;

	// State of the pin synchroniser
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
	} odsp_sync_t;

endpackage : odsp_pkg

// ===== odsp_sync.sv
/*
 * Two-flop synchroniser for the three link pins.
 * Assumes pins are asynchronous to aclk; reset values match idle but for the clock, which resets low.
 */
`timescale 1ns/1ns
module odsp_sync
	import odsp_pkg::*;
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Raw pins and synchronised copies
	input  wire logic [2:0] pins,
	output logic      [2:0] pins_s
);

	odsp_sync_t st_reg;
	odsp_sync_t st_next;

	// First stage feeds only the second
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = pins;
		st_next.s2 = st_reg.s1;
	end

	// Reset values: clock low, sync high, data low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= {3'h2, 3'h2};
		end else begin
			st_reg <= st_next;
		end
	end

	assign pins_s = st_reg.s2;

endmodule : odsp_sync

// ===== odsp_port.sv
/*
 * Octal 12-bit converter serial write port with daisy-chain output and an
 * AXI4-Lite register view. Pins are sampled by aclk, which must run well
 * above the serial clock so each serial level is seen for several cycles.
 */
`timescale 1ns/1ns
`include "odsp_defines.svh"
module odsp_port
	import odsp_pkg::*;
(
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Serial link pins
	input  wire logic         sclk,
	input  wire logic         sync_n,
	input  wire logic         din,
	output logic              dout,
	// Converter codes, low group uses reference_group_low
	output logic [47:0]       group_low_codes,
	output logic [47:0]       group_high_codes,
	output logic              write_through_mode,
	// AXI4-Lite write channels
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready
);

	odsp_state_t st_reg;
	odsp_state_t st_next;
	logic [2:0]  pins_s;
	logic        sclk_s;
	logic        sync_n_s;
	logic        din_s;
	logic        fall;
	logic        frame_end;
	logic        frame_ok;
	logic [2:0]  cmd_chan;
	logic [11:0] cmd_code;
	logic [3:0]  cmd_nib;

	// Channel word decode, shared by held and output views
	function automatic logic odsp_chan_hit(input logic [7:0] a, input logic [7:0] base);
		odsp_chan_hit = (a[7:5] == base[7:5]) && (a[1:0] == 2'h0);
	endfunction : odsp_chan_hit

	// Pins cross into aclk through two flops
	odsp_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pins    ({sclk, sync_n, din}),
		.pins_s  (pins_s)
	);

	assign sclk_s   = pins_s[2];
	assign sync_n_s = pins_s[1];
	assign din_s    = pins_s[0];

	// Link events seen from the synchronised pins
	assign fall      = st_reg.sclk_q & ~sclk_s;
	assign frame_end = (st_reg.link == LINK_FRAME) && sync_n_s;
	assign frame_ok  = (st_reg.edges >= `ODSP_EDGE_FULL) && (st_reg.pos == 4'h0);
	assign cmd_nib   = st_reg.shreg[15:12];
	assign cmd_chan  = st_reg.shreg[14:12];
	assign cmd_code  = st_reg.shreg[11:0];

	// Next-state logic for link, command execution and the bus slave
	always_comb begin
		st_next        = st_reg;
		st_next.sclk_q = sclk_s;
		case (st_reg.link)
			LINK_IDLE: begin
				// Edges in the cycle sync drops are not counted
				if (!sync_n_s && st_reg.link_en) begin
					st_next.link  = LINK_FRAME;
					st_next.edges = 5'h00;
					st_next.pos   = 4'h0;
					st_next.dout  = 1'b0;
				end
			end
			LINK_FRAME: begin
				if (sync_n_s) begin
					st_next.link = LINK_IDLE;
					st_next.dout = 1'b0;
					if (frame_ok) begin
						// Last sixteen bits are this device's command
						st_next.last_cmd = st_reg.shreg;
						if (!st_reg.shreg[15]) begin
							st_next.held[cmd_chan] = cmd_code;
							if (st_reg.wt_mode) begin
								st_next.outc[cmd_chan] = cmd_code;
							end
						end else begin
							case (cmd_nib)
								`ODSP_CMD_REG_ONLY: st_next.wt_mode = 1'b0;
								`ODSP_CMD_WR_THRU:  st_next.wt_mode = 1'b1;
								`ODSP_CMD_UPD_ALL:  st_next.outc    = st_reg.held;
								`ODSP_CMD_CHAN_A: begin
									st_next.held    = st_reg.held;
									st_next.held[0] = cmd_code;
									st_next.outc    = st_reg.held;
									st_next.outc[0] = cmd_code;
								end
								// Power-down and other commands are not modelled
								default: st_next.wt_mode = st_reg.wt_mode;
							endcase
						end
					end else begin
						// Short or ragged frame: bits dropped, state kept
						st_next.aborts = st_reg.aborts + 8'h01;
					end
				end else if (fall) begin
					st_next.shreg = {st_reg.shreg[14:0], din_s};
					st_next.pos   = st_reg.pos + 4'h1;
					if (st_reg.edges != `ODSP_EDGE_FULL) begin
						st_next.edges = st_reg.edges + 5'h01;
					end
					// Chain output: low, marker high, then delayed input
					if (st_reg.edges < `ODSP_EDGE_LOW_LAST) begin
						st_next.dout = 1'b0;
					end else if (st_reg.edges == `ODSP_EDGE_LOW_LAST) begin
						st_next.dout = 1'b1;
					end else begin
						st_next.dout = st_reg.shreg[14];
					end
				end
			end
			default: st_next.link = LINK_IDLE;
		endcase

		// Write address and data may arrive in either order
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_have = 1'b1;
			st_next.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_have = 1'b1;
			st_next.wdata  = s_axi_wdata;
			st_next.wstrb  = s_axi_wstrb;
		end
		if (st_reg.aw_have && st_reg.w_have) begin
			st_next.aw_have = 1'b0;
			st_next.w_have  = 1'b0;
			st_next.bvalid  = 1'b1;
			if (st_reg.awaddr == `ODSP_OFF_CONTROL) begin
				st_next.bresp = `ODSP_RESP_OKAY;
				if (st_reg.wstrb[0]) begin
					st_next.link_en = st_reg.wdata[`ODSP_CTRL_EN_BIT];
				end
			end else if (st_reg.awaddr == `ODSP_OFF_STATUS
				|| odsp_chan_hit(st_reg.awaddr, `ODSP_OFF_HELD_BASE)
				|| odsp_chan_hit(st_reg.awaddr, `ODSP_OFF_OUT_BASE)) begin
				// Codes change only through the serial link
				st_next.bresp = `ODSP_RESP_SLVERR;
			end else begin
				st_next.bresp = `ODSP_RESP_DECERR;
			end
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// Reads answer one cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = `ODSP_RESP_OKAY;
			st_next.rdata  = 32'h00000000;
			if (s_axi_araddr == `ODSP_OFF_CONTROL) begin
				st_next.rdata[`ODSP_CTRL_EN_BIT] = st_reg.link_en;
			end else if (s_axi_araddr == `ODSP_OFF_STATUS) begin
				st_next.rdata = {st_reg.last_cmd, st_reg.aborts, 6'h00,
					st_reg.link == LINK_FRAME, st_reg.wt_mode};
			end else if (odsp_chan_hit(s_axi_araddr, `ODSP_OFF_HELD_BASE)) begin
				st_next.rdata[11:0] = st_reg.held[s_axi_araddr[4:2]];
			end else if (odsp_chan_hit(s_axi_araddr, `ODSP_OFF_OUT_BASE)) begin
				st_next.rdata[11:0] = st_reg.outc[s_axi_araddr[4:2]];
			end else begin
				st_next.rresp = `ODSP_RESP_DECERR;
			end
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
	end

	// Synchronous reset; powers up in register-only mode, codes zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg         <= '0;
			st_reg.sclk_q  <= 1'b0;
			st_reg.link_en <= `ODSP_CTRL_EN_RST;
			st_reg.wt_mode <= `ODSP_MODE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Handshakes are combinational, data straight from flops
	assign s_axi_awready      = !st_reg.aw_have && !st_reg.bvalid;
	assign s_axi_wready       = !st_reg.w_have && !st_reg.bvalid;
	assign s_axi_bvalid       = st_reg.bvalid;
	assign s_axi_bresp        = st_reg.bresp;
	assign s_axi_arready      = !st_reg.rvalid;
	assign s_axi_rvalid       = st_reg.rvalid;
	assign s_axi_rdata        = st_reg.rdata;
	assign s_axi_rresp        = st_reg.rresp;
	assign dout               = st_reg.dout;
	assign write_through_mode = st_reg.wt_mode;
	// Channels A-D scale on the low reference, E-H on the high one
	assign group_low_codes    = st_reg.outc[3:0];
	assign group_high_codes   = st_reg.outc[7:4];

	// Checks on the link and command logic
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_shift;
		(st_reg.link == LINK_FRAME) && !sync_n_s && fall
			|=> (st_reg.shreg[0] == $past(din_s)) && (st_reg.shreg[15:1] == $past(st_reg.shreg[14:0]));
	endproperty
	a_shift: assert property (p_shift) else $error("Shift register missed a bit");

	property p_chan_write;
		frame_end && frame_ok && !st_reg.shreg[15]
			|=> st_reg.held[$past(cmd_chan)] == $past(cmd_code);
	endproperty
	a_chan_write: assert property (p_chan_write) else $error("Channel register not written");

	property p_write_through;
		frame_end && frame_ok && !st_reg.shreg[15] && st_reg.wt_mode
			|=> st_reg.outc[$past(cmd_chan)] == $past(cmd_code);
	endproperty
	a_write_through: assert property (p_write_through) else $error("Output not updated");

	property p_abort;
		frame_end && (st_reg.edges < `ODSP_EDGE_ABORT)
			|=> $stable(st_reg.held) && $stable(st_reg.outc) && $stable(st_reg.wt_mode)
				&& (st_reg.aborts == $past(st_reg.aborts) + 8'h01);
	endproperty
	a_abort: assert property (p_abort) else $error("Aborted frame changed state");

	property p_dout_low;
		(st_reg.link == LINK_FRAME) && (st_reg.edges <= `ODSP_EDGE_LOW_LAST) |-> !st_reg.dout;
	endproperty
	a_dout_low: assert property (p_dout_low) else $error("Chain output high too early");

	property p_dout_mark;
		(st_reg.link == LINK_FRAME) && !sync_n_s && fall && (st_reg.edges == `ODSP_EDGE_LOW_LAST)
			|=> st_reg.dout ##1 st_reg.dout [*1];
	endproperty
	a_dout_mark: assert property (p_dout_mark) else $error("Chain marker missing on edge 15");

	property p_mode;
		frame_end && frame_ok && (cmd_nib == `ODSP_CMD_WR_THRU) |=> st_reg.wt_mode;
	endproperty
	a_mode: assert property (p_mode) else $error("Write-through mode not entered");

	property p_update_all;
		frame_end && frame_ok && (cmd_nib == `ODSP_CMD_UPD_ALL)
			|=> (st_reg.outc == $past(st_reg.held)) && $stable(st_reg.wt_mode);
	endproperty
	a_update_all: assert property (p_update_all) else $error("Update-all mismatch");

	property p_no_exec_ragged;
		frame_end && !frame_ok |=> $stable(st_reg.last_cmd) && (st_reg.link == LINK_IDLE);
	endproperty
	a_no_exec_ragged: assert property (p_no_exec_ragged) else $error("Ragged frame executed");

	// Past the marker the chain output repeats the bit sent fifteen edges earlier
	property p_dout_data;
		(st_reg.link == LINK_FRAME) && !sync_n_s && fall && (st_reg.edges > `ODSP_EDGE_LOW_LAST)
			|=> st_reg.dout == $past(st_reg.shreg[14]);
	endproperty
	a_dout_data: assert property (p_dout_data) else $error("Chain output lost a bit");

	// Between frames the chain output rests low
	property p_idle_quiet;
		(st_reg.link == LINK_IDLE) |-> !st_reg.dout;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("Chain output high while idle");

	property p_frame_start;
		(st_reg.link == LINK_IDLE) && !sync_n_s && st_reg.link_en
			|=> (st_reg.link == LINK_FRAME) && (st_reg.edges == 5'h00) && (st_reg.pos == 4'h0);
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("Frame start not taken");

	// Edge count saturates at sixteen, so only lower counts must advance
	property p_edge_count;
		(st_reg.link == LINK_FRAME) && !sync_n_s && fall && (st_reg.edges < `ODSP_EDGE_FULL)
			|=> st_reg.edges == $past(st_reg.edges) + 5'h01;
	endproperty
	a_edge_count: assert property (p_edge_count) else $error("Falling edge not counted");

	// Without a falling edge nothing may shift
	property p_no_fall_hold;
		(st_reg.link == LINK_FRAME) && !sync_n_s && !fall
			|=> $stable(st_reg.shreg) && $stable(st_reg.edges);
	endproperty
	a_no_fall_hold: assert property (p_no_fall_hold) else $error("Shift without a falling edge");

	property p_reg_only_write;
		frame_end && frame_ok && !st_reg.shreg[15] && !st_reg.wt_mode
			|=> $stable(st_reg.outc) && !st_reg.wt_mode;
	endproperty
	a_reg_only_write: assert property (p_reg_only_write) else $error("Output moved in register-only mode");

	property p_chan_mode_kept;
		frame_end && frame_ok && !st_reg.shreg[15] |=> $stable(st_reg.wt_mode);
	endproperty
	a_chan_mode_kept: assert property (p_chan_mode_kept) else $error("Channel write changed mode");

	property p_reg_only_mode;
		frame_end && frame_ok && (cmd_nib == `ODSP_CMD_REG_ONLY)
			|=> !st_reg.wt_mode && $stable(st_reg.held) && $stable(st_reg.outc);
	endproperty
	a_reg_only_mode: assert property (p_reg_only_mode) else $error("Register-only mode not entered");

	// Channel A write also pushes every other held code out, in either mode
	property p_chan_a;
		frame_end && frame_ok && (cmd_nib == `ODSP_CMD_CHAN_A)
			|=> (st_reg.held[0] == $past(cmd_code)) && (st_reg.outc[0] == $past(cmd_code))
				&& (st_reg.outc[7:1] == $past(st_reg.held[7:1])) && $stable(st_reg.wt_mode);
	endproperty
	a_chan_a: assert property (p_chan_a) else $error("Channel A command mismatch");

	// Unmodelled commands execute as no-ops
	property p_ignored_cmd;
		frame_end && frame_ok && (cmd_nib >= 4'hc)
			|=> $stable(st_reg.held) && $stable(st_reg.outc) && $stable(st_reg.wt_mode);
	endproperty
	a_ignored_cmd: assert property (p_ignored_cmd) else $error("Unused command changed state");

endmodule : odsp_port

// ===== odsp_host.sv
/*
 * Host serial controller model driving the link pins of the port.
 * Assumes the bench calls frame() and that aclk edges fall on 5 ns steps.
 */
`timescale 1ns/1ns
module odsp_host
(
	// Link pins toward the port
	output logic      sclk,
	output logic      sync_n,
	output logic      din,
	input  wire logic dout
);
	// Idle levels: clock parked high, sync high, data low
	initial begin
		sclk = 1'b1;
		sync_n = 1'b1;
		din = 1'b0;
	end

	// One frame of n bits, msb first; seen[k-1] is dout after fall k
	task automatic frame(input logic [63:0] bits, input int n, output logic [63:0] seen);
		seen = '0;
		#3; // Keeps pin edges off aclk edges
		sync_n = 1'b0; // clock is high here
		#80;
		for (int i = 0; i < n; i++) begin
			din = bits[n-1-i];
			#40 sclk = 1'b0;
			#60 seen[i] = dout;
			#20 sclk = 1'b1;
			#40;
		end
		sync_n = 1'b1; // before any further fall
		din = 1'b0;
		#160; // high time well above three aclk
	endtask : frame
endmodule : odsp_host

// ===== tb.sv
/*
 * Self-checking bench for the serial write port and its register view.
 * Assumes odsp_host drives the link; expectations come from a local model.
 */
`timescale 1ns/1ns
module tb
	import odsp_pkg::*;
;
	// Design pins
	logic        aclk, aresetn, sclk, sync_n, din, dout, write_through_mode;
	logic [47:0] group_low_codes, group_high_codes;
	logic [95:0] all_out;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	// Bench state and expected model
	int          mismatches, checked;
	logic [11:0] held_e[8], out_e[8];
	logic        wt_e, en_e;
	logic [15:0] last_e;
	logic [7:0]  ab_e;

	odsp_port dut_u(.aclk, .aresetn, .sclk, .sync_n, .din, .dout, .group_low_codes, .group_high_codes,
		.write_through_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	odsp_host host_u(.sclk, .sync_n, .din, .dout);

	// Channel A sits lowest, H highest
	assign all_out = {group_high_codes, group_low_codes};

	// Free-running system clock
	always #5 aclk = ~aclk;

	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task report_and_stop;
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// Write one word; ready is sampled at the negedge before the taking edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic       ta, tw, tk;
		logic [1:0] r;
		tk = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Only the watchdog ends a wait that never completes
		while (!tk) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tk = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		// One idle edge, so a following call never re-raises bready in this step
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		chk(48'(r), 48'(er));
	endtask : axi_wr

	// Read one word and judge data and response
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic        ta, tk;
		logic [31:0] d;
		logic [1:0]  r;
		tk = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		// Only the watchdog ends a wait that never completes
		while (!tk) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tk = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		// One idle edge, so a following call never re-raises rready in this step
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		chk(48'(d), 48'(e));
		chk(48'(r), 48'(er));
	endtask : axi_rd

	// Outputs, held registers, mode and status against the model
	task automatic check_all;
		for (int c = 0; c < 8; c++) begin
			chk(48'(all_out[c*12 +: 12]), 48'(out_e[c]));
			axi_rd(8'h20 + 8'(4 * c), 32'(held_e[c]), 2'h0);
		end
		chk(48'(write_through_mode), 48'(wt_e));
		axi_rd(8'h04, {last_e, ab_e, 7'h00, wt_e}, 2'h0);
	endtask : check_all

	// Send a frame, judge the chain output, apply the rules to the model
	task automatic run(input logic [63:0] b, input int n);
		logic [63:0] s;
		logic [15:0] w;
		logic        ok;
		w = b[15:0];
		host_u.frame(b, n, s);
		@(posedge aclk);
		ok = en_e && n >= 16 && n % 16 == 0;
		// A disabled port must keep its chain output low throughout
		for (int k = 1; k <= n; k++)
			chk(48'(s[k-1]), 48'(en_e && (k < 15 ? 1'b0 : k == 15 ? 1'b1 : b[n-k+15])));
		if (en_e && !ok) ab_e++;
		if (ok) begin
			last_e = w;
			case (w[15:12])
				4'h8: wt_e = 1'b0;
				4'h9: wt_e = 1'b1;
				4'ha: out_e = held_e;
				4'hb: begin
					held_e[0] = w[11:0];
					out_e = held_e;
				end
				// Unused commands leave codes and mode alone
				4'hc, 4'hd, 4'he, 4'hf: ;
				default: begin
					held_e[w[14:12]] = w[11:0];
					if (wt_e) out_e[w[14:12]] = w[11:0];
				end
			endcase
		end
		check_all;
	endtask : run

	// Hang guard
	initial begin
		#500000;
		mismatches++;
		report_and_stop;
	end

	// Main sequence
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		mismatches = 0;
		checked = 0;
		foreach (held_e[i]) held_e[i] = 12'h000;
		out_e = held_e;
		{wt_e, en_e, last_e, ab_e} = {1'b0, 1'b1, 16'h0000, 8'h00};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check_all;
		for (int c = 0; c < 8; c++)
			run({48'h0, 1'b0, 3'(c), 12'(c * 12'h249)}, 16);
		run(64'ha000, 16);
		run(64'h9000, 16);
		run(64'h5abc, 16);
		run(64'h8000, 16);
		run(64'h1321, 16);
		run(64'hb7e5, 16);
		run(64'hc123, 16);
		run(64'h2468, 8);
		run(64'h3fed, 15);
		run(64'hf4321, 20);
		run(64'h7123_6abc, 32);
		run(64'h0111_2222_3333, 48);
		axi_wr(8'h00, 32'h0, 2'h0);
		en_e = 1'b0;
		run(64'h4999, 16);
		axi_wr(8'h00, 32'h1, 2'h0);
		en_e = 1'b1;
		axi_rd(8'h00, 32'h1, 2'h0);
		axi_wr(8'h04, 32'h1, 2'h2);
		axi_wr(8'h80, 32'h1, 2'h3);
		axi_rd(8'h80, 32'h0, 2'h3);
		report_and_stop;
	end
endmodule : tb
